// ---- rtl/mlb_defs.svh ----
// Constants for the microcontroller local bus port
`ifndef MLB_DEFS_SVH
`define MLB_DEFS_SVH
`define MLB_DATA_W       8
`define MLB_ADDR_W       7
`define MLB_SEL_BIT      7
`define MLB_SEL_INTERNAL 1'h0
`define MLB_ADDR_RST     7'h00
`define MLB_DATA_RST     8'h00
`define MLB_STYLE_LE     1'h0
// Pin synchroniser reset: strap open, latch low, strobes idle high, bus clear
`define MLB_SYNC_RST     12'hB00
// Last settling count, reached once the synchronisers hold real pin levels
`define MLB_SETTLE_LAST  2'h2
`endif

// ---- rtl/mlb_pkg.sv ----
// Types for the microcontroller local bus port
`default_nettype none
package mlb_pkg;
	// Internal register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} mlb_req_t;
	// Bus phase states
	typedef enum logic [2:0] {
		MLB_IDLE  = 3'h1,
		MLB_WRITE = 3'h2,
		MLB_READ  = 3'h4
	} mlb_state_t;
endpackage
`default_nettype wire

// ---- rtl/mlb_port.sv ----
// Multiplexed address/data bus port toward the internal registers
// Functional notes
// - One shared 8-bit tri-state bus carries address then data.
// - Latch-enable style: address captured at falling edge of latch enable.
// - Address-strobe style: address captured at rising edge of address strobe.
// - Access selects internal registers only when latched top bit is zero.
// - Latch-enable style: write strobe writes register, read strobe drives bus.
// - Address-strobe style: data strobe low, direction low writes, high reads.
// - Pulled-up strap sampled: grounded latch-enable style, open address-strobe style.
`timescale 1ns/100ps
`default_nettype none
`include "mlb_defs.svh"

module mlb_port (
	input  wire logic                   CORE_CLK,
	input  wire logic                   RST,
	input  wire logic                   CE,
	input  wire logic                   CONFIG_STRAP,
	input  wire logic                   ALE_AS,
	input  wire logic                   RD_DS,
	input  wire logic                   WR_RW,
	input  wire logic [7:0]             AD_IN,
	output logic      [7:0]             AD_OUT,
	output logic                        AD_OE_N,
	output mlb_pkg::mlb_req_t           REQ,
	input  wire logic [7:0]             REG_RDATA
);
	// Two-stage synchronisers on all pin inputs
	logic [11:0] sync1;
	logic [11:0] sync2;
	// Settling count while the synchronisers fill after reset
	logic [1:0]  settle;
	logic        strap_taken;
	logic        strap_style;
	// Address latch state
	logic        ale_q;
	logic [6:0]  addr;
	logic        addr_sel;
	// Request and read drive state
	logic        rd_q;
	logic [7:0]  rdata;
	mlb_pkg::mlb_state_t state;
	mlb_pkg::mlb_state_t next_state;

	// Pins sampled twice before any logic reads them
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sync1 <= `MLB_SYNC_RST;
			sync2 <= `MLB_SYNC_RST;
		end else if (CE) begin
			sync1 <= {CONFIG_STRAP, ALE_AS, RD_DS, WR_RW, AD_IN};
			sync2 <= sync1;
		end
	end

	wire       s_strap = sync2[11];
	wire       s_ale   = sync2[10];
	wire       s_rd    = sync2[9];
	wire       s_wr    = sync2[8];
	wire [7:0] s_ad    = sync2[7:0];

	// Strap taken once the synchronisers hold pin levels, not their reset values
	// Taking it earlier would read the reset pattern and pick the wrong style
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			settle      <= 2'h0;
			strap_taken <= 1'h0;
			strap_style <= `MLB_STYLE_LE;
		end else if (CE) begin
			if (settle != `MLB_SETTLE_LAST) begin
				settle <= settle + 2'h1;
			end else if (!strap_taken) begin
				strap_taken <= 1'h1;
				strap_style <= s_strap;
			end
		end
	end
	// Selected bus style, fixed until the next reset
	wire style_le = (strap_style == `MLB_STYLE_LE);

	// Address capture edge per bus style, held off until the style is known
	// The latch follower settles meanwhile, so no false edge follows reset
	wire ale_fall = ale_q && !s_ale;
	wire as_rise  = !ale_q && s_ale;
	wire capture  = strap_taken && (style_le ? ale_fall : as_rise);

	// Latch follower and address register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ale_q    <= 1'h0;
			addr     <= `MLB_ADDR_RST;
			addr_sel <= 1'h0;
		end else if (CE) begin
			ale_q <= s_ale;
			if (capture) begin
				addr     <= s_ad[6:0];
				addr_sel <= (s_ad[`MLB_SEL_BIT] == `MLB_SEL_INTERNAL);
			end
		end
	end

	// Strobe qualification per style, suppressed on the capture cycle
	wire wr_act = style_le ? !s_wr : (!s_rd && !s_wr);
	wire rd_act = style_le ? !s_rd : (!s_rd && s_wr);
	wire wr_q   = wr_act && addr_sel && !capture;
	wire rd_qq  = rd_act && addr_sel && !capture;

	// One write pulse per strobe, read held while strobe lasts
	always_comb begin
		next_state = mlb_pkg::MLB_IDLE;
		case (state)
			mlb_pkg::MLB_IDLE: begin
				if (wr_q)
					next_state = mlb_pkg::MLB_WRITE;
				else if (rd_qq)
					next_state = mlb_pkg::MLB_READ;
			end
			mlb_pkg::MLB_WRITE: next_state = wr_act ? mlb_pkg::MLB_WRITE : mlb_pkg::MLB_IDLE;
			mlb_pkg::MLB_READ:  next_state = rd_qq ? mlb_pkg::MLB_READ : mlb_pkg::MLB_IDLE;
			default:            next_state = mlb_pkg::MLB_IDLE;
		endcase
	end

	// Request pulses, write data and read data registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state <= mlb_pkg::MLB_IDLE;
			REQ   <= '0;
			rd_q  <= 1'h0;
			rdata <= `MLB_DATA_RST;
		end else if (CE) begin
			state     <= next_state;
			REQ.addr  <= addr;
			REQ.wdata <= s_ad;
			REQ.wr    <= (state == mlb_pkg::MLB_IDLE) && wr_q;
			REQ.rd    <= (state == mlb_pkg::MLB_IDLE) && rd_qq;
			rd_q      <= (next_state == mlb_pkg::MLB_READ);
			rdata     <= REG_RDATA;
		end
	end

	// Bus drive, enable low while driving
	assign AD_OUT  = rdata;
	assign AD_OE_N = !rd_q;

	// Latch edges as seen behind the synchronisers
	sequence le_fall_s;
		(CE && strap_taken && style_le && s_ale) ##1 (CE && !s_ale);
	endsequence
	sequence as_rise_s;
		(CE && strap_taken && !style_le && !s_ale) ##1 (CE && s_ale);
	endsequence

	// Request pulses last one cycle
	a_lone_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		REQ.wr |=> !REQ.wr)
		else $error("write pulse longer than one cycle");
	a_read_once: assert property (@(posedge CORE_CLK) disable iff (RST)
		REQ.rd |=> !REQ.rd)
		else $error("read pulse longer than one cycle");
	// Write data is the bus byte seen behind the strobe
	a_wdata_take: assert property (@(posedge CORE_CLK) disable iff (RST)
		REQ.wr |-> REQ.wdata == $past(s_ad))
		else $error("write data not taken from bus");

	// Bus driven only behind a qualified read and released once it ends
	a_drive_qual: assert property (@(posedge CORE_CLK) disable iff (RST)
		!AD_OE_N |-> $past(rd_act) && addr_sel)
		else $error("bus driven without read");
	a_drive_end: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && !rd_act) |=> AD_OE_N)
		else $error("bus held after read ended");
	a_reset_out: assert property (@(posedge CORE_CLK)
		RST |=> AD_OE_N && !REQ.wr && !REQ.rd)
		else $error("outputs active after reset");

	// Addresses outside the internal range raise no request
	a_ext_ignore: assert property (@(posedge CORE_CLK) disable iff (RST)
		REQ.wr |-> $past(addr_sel))
		else $error("access outside internal range");
	a_sel_top: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && capture) |=> addr_sel == !$past(s_ad[7]))
		else $error("select bit misdecoded");

	// Address register holds between captures and loads on the style's edge
	a_addr_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && !capture) |=> $stable(addr))
		else $error("address changed without capture");
	a_addr_take: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && capture) |=> addr == $past(s_ad[6:0]))
		else $error("address not captured");
	a_le_take: assert property (@(posedge CORE_CLK) disable iff (RST)
		le_fall_s |=> addr == $past(s_ad[6:0]))
		else $error("address missed at latch fall");
	a_as_take: assert property (@(posedge CORE_CLK) disable iff (RST)
		as_rise_s |=> addr == $past(s_ad[6:0]))
		else $error("address missed at strobe rise");
	a_as_edge: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && $past(CE) && !style_le && capture) |-> s_ale && !$past(s_ale))
		else $error("capture without strobe rise");

	// Style fixed once the strap is taken
	a_style_fix: assert property (@(posedge CORE_CLK) disable iff (RST)
		strap_taken |=> $stable(strap_style))
		else $error("style changed after strap");

	// Request direction follows the strobes of each style
	a_rw_dir: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && !style_le && state == mlb_pkg::MLB_IDLE && wr_q) |=> REQ.wr && !REQ.rd)
		else $error("direction line misread");
	a_le_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		(style_le && REQ.wr) |-> !$past(s_wr))
		else $error("write without write strobe");
	a_le_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		(style_le && REQ.rd) |-> !$past(s_rd))
		else $error("read without read strobe");
	a_as_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!style_le && REQ.wr) |-> !$past(s_rd) && !$past(s_wr))
		else $error("write without data strobe and low direction");
	a_as_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!style_le && REQ.rd) |-> !$past(s_rd) && $past(s_wr))
		else $error("read without data strobe and high direction");
endmodule
`default_nettype wire

// ---- sim/mlb_mcu_model.sv ----
// Microcontroller model on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module mlb_mcu_model (
	input  wire logic       clk,
	output logic            ale_as,
	output logic            rd_ds,
	output logic            wr_rw,
	output logic            ad_en,
	output logic [7:0]      ad_drv
);
	// Idle: strobes high, bus released
	initial begin
		ale_as = 1'b0;
		rd_ds = 1'b1;
		wr_rw = 1'b1;
		ad_en = 1'b0;
		ad_drv = 8'h00;
	end
	// One access: address phase, then data strobe for six cycles
	task automatic bus(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d);
		#2 ad_drv = a;
		ad_en = 1'b1;
		ale_as = ~s;
		@(posedge clk);
		#2 ale_as = s; // Capture edge for either style
		repeat (4) @(posedge clk);
		#2 ad_drv = d;
		ad_en = w; // Bus released for reads
		rd_ds = w & ~s;
		wr_rw = ~w;
		repeat (6) @(posedge clk);
		#2 rd_ds = 1'b1;
		wr_rw = 1'b1;
		ad_en = 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- sim/mcu_local_bus_interface_tb.sv ----
// Self-checking bench for the local bus port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module mcu_local_bus_interface_tb;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              strap = 1'b0;
	logic              as, ds, rw, en;
	logic [7:0]        drv, ad_out, ad, reg_rdata;
	logic              oe_n;
	mlb_pkg::mlb_req_t req, w_seen;
	int                err_total = 0, tests_run = 0, n_wr = 0, n_rd = 0;
	logic [7:0]        rd_data;
	// Shared wire: device, model, or inverse of last value when released
	assign ad = !oe_n ? ad_out : en ? drv : ~drv;
	// Register file stand-in: read data follows the requested address
	assign reg_rdata = {1'h1, req.addr};
	always #25 clk = ~clk;
	mlb_mcu_model mcu (.clk(clk), .ale_as(as), .rd_ds(ds), .wr_rw(rw), .ad_en(en), .ad_drv(drv));
	mlb_port dut (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .CONFIG_STRAP(strap), .ALE_AS(as),
		.RD_DS(ds), .WR_RW(rw), .AD_IN(ad), .AD_OUT(ad_out), .AD_OE_N(oe_n), .REQ(req),
		.REG_RDATA(reg_rdata));
	// Records requests and driven read data
	always @(posedge clk) begin
		if (req.wr === 1'b1) begin
			n_wr++;
			w_seen = req;
		end
		if (req.rd === 1'b1) n_rd++;
		if (oe_n === 1'b0) rd_data = ad_out;
	end
	task automatic end_sim;
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Reset with a chosen strap level
	task automatic do_reset(input logic s);
		#2 rst = 1'b1;
		strap = s;
		repeat (3) @(posedge clk);
		#2 rst = 1'b0;
		repeat (5) @(posedge clk);
		n_wr = 0;
		n_rd = 0;
	endtask
	// Write to an internal register
	task automatic sc_write(input logic s);
		mcu.bus(s, 1'b1, 8'h15, 8'h3c);
		`CHK(n_wr, 1)
		`CHK(n_rd, 0)
		`CHK(w_seen.addr, 7'h15)
		`CHK(w_seen.wdata, 8'h3c)
	endtask
	// Read drives the bus, then releases it
	task automatic sc_read(input logic s);
		rd_data = 8'h00;
		mcu.bus(s, 1'b0, 8'h22, 8'h00);
		`CHK(n_rd, 1)
		`CHK(n_wr, 1)
		`CHK(rd_data, 8'ha2)
		`CHK(oe_n, 1'b1)
	endtask
	// Top address bit set: ignored both ways
	task automatic sc_refuse(input logic s);
		rd_data = 8'h00;
		mcu.bus(s, 1'b1, 8'h95, 8'h77);
		mcu.bus(s, 1'b0, 8'h80, 8'h00);
		`CHK(n_wr, 1)
		`CHK(n_rd, 1)
		`CHK(rd_data, 8'h00)
	endtask
	initial begin
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			sc_write(s[0]);
			sc_read(s[0]);
			sc_refuse(s[0]);
		end
		end_sim();
	end
	// Watchdog
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire
